// >>> inc/rss_pkg.sv
// Constants, register map and carrier types of the reset source sequencer.
// Assumes one 10 MHz clock and configuration bits that are static after power-up.
// Summary of operation
// - Low supply holds reset, clears brown-out flag
// - Low-power and main brown-out requests are ORed
// - Off-in-sleep mode: low-power trip re-arms power-on
// - Low-power detector enabled only by its config
// - Pin reset off only when both bits zero
// - Low pin holds reset, short pulses filtered
// - Disabled pin is input, software pull-up
// - Watchdog reset clears its flag, updates timeout
// - Reset instruction clears its flag
// - Stack faults reset when enabled, set flag
// - Programming exit behaves as device reset
// - Power-up timer holds 64 ms after release
// - Start waits for timer, pin, oscillator
// - Execution begins ten cycles after pin rise
// - Resets load 0000h, wake-ups continue next
// - Power-on loads fixed cause and status values
// - Watchdog wake clears timeout and power-down
// - Interrupt wake pushes return, vectors 0004h
// - Pin reset clears its flag, sleep case
// - Soft brown-out enable resets 1, mode 01
// - Ready bit shows circuit active, reserved zero
// - Hardware sets flags active only, software free; re-arm reloads power-on cause
package rss_pkg;
    localparam int CLK_HZ        = 10_000_000;
    localparam int POWERUP_TIMER_MS       = 64;
    localparam int POWERUP_TIMER_CYC      = POWERUP_TIMER_MS * (CLK_HZ / 1000);
    localparam int MASTER_CLEAR_PIN_DLY_CYC  = 10;
    localparam int MASTER_CLEAR_PIN_FILT_CYC = 4;
    localparam int ANA_FILT_CYC  = 1;

    localparam logic [1:0] ADDR_BORCTL = 2'h0;
    localparam logic [1:0] ADDR_CAUSE  = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;

    localparam int BC_SOFT_BROWNOUT_ENABLE = 7;
    localparam int BC_RDY    = 0;
    localparam int CR_STACK_OVERFLOW_FLAG = 7;
    localparam int CR_STACK_UNDERFLOW_FLAG = 6;
    localparam int CR_WATCHDOG_RESET_FLAG   = 4;
    localparam int CR_PIN_RESET_FLAG  = 3;
    localparam int CR_RI     = 2;
    localparam int CR_POR    = 1;
    localparam int CR_BOR    = 0;
    localparam int ST_TO     = 4;
    localparam int ST_PD     = 3;

    localparam logic [7:0] BORCTL_RST = 8'h80;
    localparam logic [7:0] CAUSE_POR  = 8'h1C;
    localparam logic [7:0] CAUSE_MASK = 8'hDF;
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [14:0] RESET_VEC = 15'h0000;
    localparam logic [14:0] INT_VEC   = 15'h0004;

    typedef enum logic [1:0] {
        BM_OFF     = 2'b00,
        BM_SW      = 2'b01,
        BM_NOSLEEP = 2'b10,
        BM_ON      = 2'b11
    } rss_bormode_t;

    typedef struct packed {
        rss_bormode_t bormode;
        logic         low_power_brownout_en;
        logic         master_clear_pin_en;
        logic         low_voltage_programming;
        logic         stack_rst_en;
        logic         powerup_timer_en_n;
        logic         ost_req;
    } rss_cfg_t;

    typedef struct packed {
        logic wdt_timeout;
        logic wdt_wake;
        logic int_wake;
        logic reset_instr;
        logic stk_ovf;
        logic stk_unf;
        logic prog_exit;
        logic sleep_enter;
        logic watchdog_clear_instruction;
        logic in_sleep;
    } rss_evt_t;
endpackage : rss_pkg

// >>> design/rss_filter.sv
// Two-flop synchroniser followed by a stability filter.
// Assumes the inputs are asynchronous; output moves only after FILT stable cycles.
`timescale 1ns/10ps
`default_nettype none
module rss_filter
    import rss_pkg::*;
#(
    parameter int W    = 1,
    parameter int FILT = 4
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    // Raw and filtered levels
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] filt
);
    localparam int CW = $clog2(FILT + 1);
    localparam logic [CW-1:0] LAST = CW'(FILT - 1);

    logic [W-1:0]  s1_reg;
    logic [W-1:0]  s2_reg;
    logic [CW-1:0] cnt_reg;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
        end
    end

    // A change must persist for FILT cycles, so short pulses never reach filt
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= '0;
            filt    <= '0;
        end else if (s2_reg == filt) begin
            cnt_reg <= '0;
        end else if (cnt_reg == LAST) begin
            cnt_reg <= '0;
            filt    <= s2_reg;
        end else begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end
endmodule : rss_filter
`default_nettype wire

// >>> design/rss_sequencer.sv
// Reset source merger, start-up sequencer and reset cause registers.
// Assumes core events are one-cycle pulses on clock; pin and comparators are asynchronous.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module rss_sequencer
    import rss_pkg::*;
#(
    parameter int POWERUP_TIMER_CYCLES = POWERUP_TIMER_CYC
) (
    // Clock and power-on reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // Configuration and core events
    input  wire rss_cfg_t    cfg,
    input  wire rss_evt_t    evt,
    input  wire logic        global_interrupt_enable,
    input  wire logic [14:0] pc_plus1,
    input  wire logic        ost_done,
    // Pin and analog comparators
    input  wire logic        master_clear_pin_pin,
    input  wire logic        sw_pullup_en,
    input  wire logic        bor_trip,
    input  wire logic        low_power_brownout_trip,
    input  wire logic        bor_ready_in,
    // Register port
    input  wire logic [1:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // Reset and restart outputs
    output logic             core_rst_n,
    output logic             restart,
    output logic      [14:0] restart_addr,
    output logic             push_return,
    output logic             pullup_en,
    output logic             gpio_in,
    output logic             bor_enable,
    output logic             por_rearm
);
    localparam int PW = $clog2(POWERUP_TIMER_CYCLES + 1);
    localparam int DW = $clog2(MASTER_CLEAR_PIN_DLY_CYC + 1);
    localparam logic [PW-1:0] POWERUP_TIMER_LAST = PW'(POWERUP_TIMER_CYCLES - 1);
    localparam logic [DW-1:0] DLY_LAST  = DW'(MASTER_CLEAR_PIN_DLY_CYC - 1);

    typedef enum logic [2:0] {S_HOLD, S_POWERUP_TIMER, S_WAIT, S_DELAY, S_RUN} rss_state_t;

    rss_state_t    state_reg;
    rss_state_t    state_next;
    logic [PW-1:0] powerup_timer_cnt_reg;
    logic [DW-1:0] dly_cnt_reg;
    logic          powerup_timer_arm_reg;
    logic [7:0]    borctl_reg;
    logic [7:0]    cause_reg;
    logic [7:0]    status_reg;
    logic          brown_q_reg;
    logic          master_clear_pin_q_reg;
    logic          vec_pend_reg;
    logic          master_clear_pin_s;
    logic [2:0]    ana_s;
    logic          bor_s;
    logic          low_power_brownout_s;
    logic          rdy_s;
    logic          bor_on;
    logic          brown_req;
    logic          master_clear_pin_active;
    logic          master_clear_pin_hold;
    logic          run;
    logic          soft_rst;
    logic          rearm_req;
    logic          osc_ok;
    logic          in_delay;

    // Pin gets a long filter; comparators only need a clean crossing
    rss_filter #(.W(1), .FILT(MASTER_CLEAR_PIN_FILT_CYC)) u_master_clear_pin_filt (
        .clock (clock),
        .nrst  (nrst),
        .raw   (master_clear_pin_pin),
        .filt  (master_clear_pin_s)
    );

    rss_filter #(.W(3), .FILT(ANA_FILT_CYC)) u_ana_filt (
        .clock (clock),
        .nrst  (nrst),
        .raw   ({bor_trip, low_power_brownout_trip, bor_ready_in}),
        .filt  (ana_s)
    );

    assign bor_s   = ana_s[2];
    assign low_power_brownout_s = ana_s[1];
    assign rdy_s   = ana_s[0];

    function automatic logic bor_mode_on(input rss_bormode_t m, input logic sb,
                                         input logic slp);
        unique case (m)
            BM_ON:      bor_mode_on = 1'b1;
            BM_NOSLEEP: bor_mode_on = !slp;
            BM_SW:      bor_mode_on = sb;
            BM_OFF:     bor_mode_on = 1'b0;
        endcase
    endfunction : bor_mode_on

    assign bor_on      = bor_mode_on(cfg.bormode, borctl_reg[BC_SOFT_BROWNOUT_ENABLE], evt.in_sleep);
    assign brown_req   = (bor_on && bor_s) || (cfg.low_power_brownout_en && low_power_brownout_s);
    assign rearm_req   = (cfg.bormode == BM_NOSLEEP) && cfg.low_power_brownout_en && low_power_brownout_s;
    assign master_clear_pin_active = cfg.master_clear_pin_en || cfg.low_voltage_programming;
    assign master_clear_pin_hold   = master_clear_pin_active && !master_clear_pin_s;
    assign run         = (state_reg == S_RUN);
    assign soft_rst    = evt.wdt_timeout || evt.reset_instr || evt.prog_exit
                      || (cfg.stack_rst_en && (evt.stk_ovf || evt.stk_unf));
    assign osc_ok      = !cfg.ost_req || ost_done;
    assign in_delay    = (state_reg == S_DELAY);

    // Merge every source into one reset and walk the start-up steps
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_HOLD: begin
                if (!brown_req) begin
                    state_next = (powerup_timer_arm_reg && !cfg.powerup_timer_en_n) ? S_POWERUP_TIMER : S_WAIT;
                end
            end
            S_POWERUP_TIMER: begin
                if (powerup_timer_cnt_reg == POWERUP_TIMER_LAST) begin
                    state_next = S_WAIT;
                end
            end
            S_WAIT: begin
                if (osc_ok && !master_clear_pin_hold) begin
                    state_next = S_DELAY;
                end
            end
            S_DELAY: begin
                if (master_clear_pin_hold) begin
                    state_next = S_WAIT;
                end else if (dly_cnt_reg == DLY_LAST) begin
                    state_next = S_RUN;
                end
            end
            S_RUN: begin
                if (soft_rst) begin
                    state_next = S_HOLD;
                end else if (master_clear_pin_hold) begin
                    state_next = S_WAIT;
                end
            end
        endcase
        if (brown_req) begin
            state_next = S_HOLD;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg  <= S_HOLD;
            core_rst_n <= 1'b0;
        end else begin
            state_reg  <= state_next;
            core_rst_n <= (state_next == S_RUN);
        end
    end

    // Timer counts on its own; the pin is only looked at afterwards
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            powerup_timer_cnt_reg <= '0;
            powerup_timer_arm_reg <= 1'b1;
            dly_cnt_reg  <= '0;
        end else begin
            powerup_timer_cnt_reg <= (state_reg == S_POWERUP_TIMER) ? powerup_timer_cnt_reg + PW'(1) : '0;
            dly_cnt_reg  <= (state_reg == S_DELAY) ? dly_cnt_reg + DW'(1) : '0;
            if (brown_req) begin
                powerup_timer_arm_reg <= 1'b1;
            end else if (state_reg == S_POWERUP_TIMER) begin
                powerup_timer_arm_reg <= 1'b0;
            end
        end
    end

    // Restart vector: reset vector on release, next address on wake-up
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            restart      <= 1'b0;
            restart_addr <= RESET_VEC;
            push_return  <= 1'b0;
            vec_pend_reg <= 1'b0;
        end else begin
            restart      <= 1'b0;
            push_return  <= 1'b0;
            vec_pend_reg <= 1'b0;
            if (state_next == S_RUN && !run) begin
                restart      <= 1'b1;
                restart_addr <= RESET_VEC;
            end else if (vec_pend_reg && run) begin
                restart      <= 1'b1;
                restart_addr <= INT_VEC;
                push_return  <= 1'b1;
            end else if (run && !soft_rst && (evt.wdt_wake || evt.int_wake)) begin
                restart      <= 1'b1;
                restart_addr <= pc_plus1;
                vec_pend_reg <= evt.int_wake && global_interrupt_enable;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            brown_q_reg <= 1'b0;
            // Filter starts low, so treat the pin as already held: no false pin event
            master_clear_pin_q_reg  <= 1'b1;
            por_rearm   <= 1'b0;
            pullup_en   <= 1'b1;
            gpio_in     <= 1'b0;
            bor_enable  <= 1'b0;
        end else begin
            brown_q_reg <= brown_req;
            master_clear_pin_q_reg  <= master_clear_pin_hold;
            por_rearm   <= rearm_req;
            pullup_en   <= master_clear_pin_active ? 1'b1 : sw_pullup_en;
            gpio_in     <= master_clear_pin_active ? 1'b0 : master_clear_pin_s;
            bor_enable  <= bor_on;
        end
    end

    // Cause flags: hardware only drives a flag active, except the re-arm load of power-on values; same-cycle event beats a write
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cause_reg  <= CAUSE_POR;
            status_reg <= STATUS_RST;
        end else begin
            if (wr && addr == ADDR_CAUSE) begin
                cause_reg <= wdata & CAUSE_MASK;
            end
            if (evt.watchdog_clear_instruction && run) begin
                status_reg[ST_TO] <= 1'b1;
                status_reg[ST_PD] <= 1'b1;
            end
            if (evt.sleep_enter && run) begin
                status_reg[ST_TO] <= 1'b1;
                status_reg[ST_PD] <= 1'b0;
            end
            if (run && evt.wdt_wake) begin
                status_reg[ST_TO] <= 1'b0;
                status_reg[ST_PD] <= 1'b0;
            end
            if (run && evt.int_wake) begin
                status_reg[ST_TO] <= 1'b1;
                status_reg[ST_PD] <= 1'b0;
            end
            if (evt.wdt_timeout) begin
                cause_reg[CR_WATCHDOG_RESET_FLAG] <= 1'b0;
                status_reg[ST_TO]  <= 1'b0;
            end
            if (evt.reset_instr) begin
                cause_reg[CR_RI] <= 1'b0;
            end
            if (cfg.stack_rst_en && evt.stk_ovf) begin
                cause_reg[CR_STACK_OVERFLOW_FLAG] <= 1'b1;
            end
            if (cfg.stack_rst_en && evt.stk_unf) begin
                cause_reg[CR_STACK_UNDERFLOW_FLAG] <= 1'b1;
            end
            if (master_clear_pin_hold && !master_clear_pin_q_reg) begin
                cause_reg[CR_PIN_RESET_FLAG] <= 1'b0;
                if (evt.in_sleep) begin
                    status_reg[ST_TO] <= 1'b1;
                    status_reg[ST_PD] <= 1'b0;
                end
            end
            if (brown_req && !brown_q_reg) begin
                status_reg <= STATUS_RST;
            end
            if (brown_req) begin
                cause_reg[CR_BOR] <= 1'b0;
            end
            if (rearm_req) begin
                cause_reg <= CAUSE_POR & ~(8'h01 << CR_BOR);
            end
        end
    end

    // Reserved bits 6:1 are never stored, so they always read zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            borctl_reg <= BORCTL_RST;
        end else if (wr && addr == ADDR_BORCTL) begin
            borctl_reg[BC_SOFT_BROWNOUT_ENABLE] <= wdata[BC_SOFT_BROWNOUT_ENABLE];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else if (rd) begin
            unique case (addr)
                ADDR_BORCTL: rdata <= {borctl_reg[BC_SOFT_BROWNOUT_ENABLE], 6'h00, bor_on && rdy_s};
                ADDR_CAUSE:  rdata <= cause_reg;
                ADDR_STATUS: rdata <= status_reg;
                default:     rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_int_wake;
        run && !soft_rst && evt.int_wake && global_interrupt_enable && !vec_pend_reg;
    endsequence

    sequence s_vectored;
        restart ##1 (restart && push_return && restart_addr == INT_VEC);
    endsequence

    a_brown_hold: assert property (brown_req |=> !core_rst_n)
        else $error("brown-out did not hold reset");
    a_brown_flag: assert property (brown_req |=> !cause_reg[CR_BOR])
        else $error("brown-out flag not cleared");
    a_por_rearm: assert property (rearm_req |=> por_rearm && cause_reg[CR_POR] == 1'b0)
        else $error("power-on not re-armed");
    a_low_power_brownout_gate: assert property ((!cfg.low_power_brownout_en && !bor_on) |-> !brown_req)
        else $error("brown-out request without enabled detector");
    a_master_clear_pin_gate: assert property ((!cfg.master_clear_pin_en && !cfg.low_voltage_programming) |-> !master_clear_pin_hold)
        else $error("pin reset while disabled");
    a_master_clear_pin_hold: assert property (master_clear_pin_hold |=> !core_rst_n)
        else $error("low pin did not hold reset");
    a_pullup_sw: assert property (!master_clear_pin_active |=> pullup_en == $past(sw_pullup_en))
        else $error("pull-up not under software control");
    a_wdt_flags: assert property (evt.wdt_timeout |=> !cause_reg[CR_WATCHDOG_RESET_FLAG] && !status_reg[ST_TO])
        else $error("watchdog reset flags wrong");
    a_ri_flag: assert property (evt.reset_instr |=> !cause_reg[CR_RI] && !core_rst_n)
        else $error("reset instruction flag wrong");
    a_stack_flag: assert property ((cfg.stack_rst_en && evt.stk_ovf) |=> cause_reg[CR_STACK_OVERFLOW_FLAG])
        else $error("stack overflow flag not set");
    a_powerup_timer_len: assert property ($rose(state_reg == S_POWERUP_TIMER) ##1 !brown_req [*8] |-> !core_rst_n)
        else $error("power-up timer released early");
    a_pin_delay: assert property ($rose(core_rst_n) |-> $past(in_delay, 10) && !$past(in_delay, 11))
        else $error("start not ten cycles after pin release");
    a_reset_vec: assert property ($rose(core_rst_n) |-> restart && restart_addr == RESET_VEC)
        else $error("release without reset vector");
    a_int_vector: assert property (s_int_wake |=> s_vectored)
        else $error("interrupt wake did not vector");
endmodule : rss_sequencer
`default_nettype wire

// >>> sim/rss_partner.sv
// Model of the reset pin driver, supply monitors and oscillator start-up timer.
// Assumes the bench steers it with level requests changed just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module rss_partner #(
    parameter int OST_CYC = 8
) (
    // Clock and power-on reset
    input  wire logic clock,
    input  wire logic nrst,
    // Requests from the bench
    input  wire logic pin_low,
    input  wire logic supply_low,
    input  wire logic lp_low,
    // Pin and comparator outputs
    output logic      master_clear_pin_pin,
    output logic      bor_trip,
    output logic      low_power_brownout_trip,
    output logic      bor_ready_in,
    output var logic  ost_done
);
    int ost_cnt;

    // Released pin floats up through its weak pull-up
    assign master_clear_pin_pin   = ~pin_low;
    assign bor_trip   = supply_low;
    assign low_power_brownout_trip = lp_low;

    // Start-up timer ignores the pin, as on the real part
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ost_cnt      <= 0;
            ost_done     <= 1'b0;
            bor_ready_in <= 1'b0;
        end else begin
            bor_ready_in <= 1'b1;
            if (ost_cnt < OST_CYC) ost_cnt <= ost_cnt + 1;
            ost_done <= (ost_cnt >= OST_CYC - 1);
        end
    end
endmodule : rss_partner
`default_nettype wire

// >>> sim/test_reset_source_sequencer.sv
// Self-checking bench of the reset source sequencer with a pin and supply model.
// Assumes a shortened power-up timer of 20 cycles.
`timescale 1ns/10ps
`default_nettype none
module test_reset_source_sequencer;
    import rss_pkg::*;
    localparam int POWERUP_TIMER_SIM = 20;
    typedef struct packed {
        rss_evt_t    e;
        logic [7:0]  cause;
        logic [7:0]  stat;
        logic [1:0]  kind;
        logic [14:0] addr;
    } rss_row_t;

    logic clock, nrst, global_interrupt_enable, ost_done, master_clear_pin_pin, sw_pullup_en, bor_trip, low_power_brownout_trip;
    logic bor_ready_in, wr, rd, core_rst_n, restart, push_return, pullup_en, gpio_in;
    logic bor_enable, por_rearm, pin_low, supply_low, lp_low, push_seen;
    logic [1:0]  addr;
    logic [7:0]  wdata, rdata;
    logic [14:0] pc_plus1, restart_addr;
    rss_cfg_t    cfg;
    rss_evt_t    evt;
    int          fail_count, checks_done, cyc, n;
    rss_row_t    rows [9];

    rss_sequencer #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_SIM)) dut (.clock(clock), .nrst(nrst), .cfg(cfg),
        .evt(evt), .global_interrupt_enable(global_interrupt_enable), .pc_plus1(pc_plus1), .ost_done(ost_done), .master_clear_pin_pin(master_clear_pin_pin),
        .sw_pullup_en(sw_pullup_en), .bor_trip(bor_trip), .low_power_brownout_trip(low_power_brownout_trip),
        .bor_ready_in(bor_ready_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .core_rst_n(core_rst_n), .restart(restart),
        .restart_addr(restart_addr), .push_return(push_return), .pullup_en(pullup_en),
        .gpio_in(gpio_in), .bor_enable(bor_enable), .por_rearm(por_rearm));
    rss_partner partner (.clock(clock), .nrst(nrst), .pin_low(pin_low),
        .supply_low(supply_low), .lp_low(lp_low), .master_clear_pin_pin(master_clear_pin_pin), .bor_trip(bor_trip),
        .low_power_brownout_trip(low_power_brownout_trip), .bor_ready_in(bor_ready_in), .ost_done(ost_done));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task stop_test;
        $display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    // Hang guard: the whole sequence needs well under two thousand cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (push_return === 1'b1) push_seen <= 1'b1;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk

    task wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_chk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #10 chk(16'(rdata), 16'(e));
    endtask : rd_chk

    task wait_run(output int cnt);
        cnt = 0;
        while (core_rst_n !== 1'b1 && cnt < 300) begin
            @(posedge clock);
            cnt++;
        end
        #10 chk(16'(cnt < 300), 16'h0001);
    endtask : wait_run

    task pulse(input rss_evt_t e);
        @(posedge clock);
        evt <= e;
        @(posedge clock);
        evt <= '0;
        repeat (2) @(posedge clock);
    endtask : pulse

    initial begin
        cfg = '{bormode: BM_ON, low_power_brownout_en: 1'b1, master_clear_pin_en: 1'b1, low_voltage_programming: 1'b0,
                stack_rst_en: 1'b1, powerup_timer_en_n: 1'b0, ost_req: 1'b1};
        {nrst, global_interrupt_enable, wr, rd, sw_pullup_en, supply_low, lp_low, push_seen} = '0;
        evt = '0; addr = '0; wdata = '0; pc_plus1 = 15'h1234; pin_low = 1'b1;
        fail_count = 0; checks_done = 0; cyc = 0;
        rows = '{'{10'h200, 8'h0F, 8'h08, 2'd1, RESET_VEC}, '{10'h002, 8'h1F, 8'h18, 2'd0, 0},
                 '{10'h040, 8'h1B, 8'h18, 2'd1, RESET_VEC}, '{10'h020, 8'h9F, 8'h18, 2'd1, 0},
                 '{10'h010, 8'h5F, 8'h18, 2'd1, RESET_VEC}, '{10'h008, 8'h1F, 8'h18, 2'd1, 0},
                 '{10'h004, 8'h1F, 8'h10, 2'd0, 0}, '{10'h100, 8'h1F, 8'h00, 2'd2, 15'h1234},
                 '{10'h080, 8'h1F, 8'h10, 2'd2, INT_VEC}};
        repeat (20) @(posedge clock);
        chk(16'({core_rst_n, pullup_en}), 16'h0001);
        nrst <= 1'b1;
        rd_chk(ADDR_CAUSE, CAUSE_POR);
        rd_chk(ADDR_STATUS, STATUS_RST);
        repeat (60) @(posedge clock);
        chk(16'(core_rst_n), 16'h0000);
        pin_low <= 1'b0;
        wait_run(n);
        chk(16'(n >= 10 && n <= 18), 16'h0001);
        chk(16'(restart_addr), 16'(RESET_VEC));
        wr_reg(ADDR_BORCTL, 8'hFF);
        rd_chk(ADDR_BORCTL, 8'h81);
        wr_reg(ADDR_BORCTL, 8'h00);
        rd_chk(ADDR_BORCTL, 8'h01);
        wr_reg(ADDR_STATUS, 8'h00);
        rd_chk(ADDR_STATUS, STATUS_RST);
        rd_chk(2'h3, 8'h00);
        chk(16'(bor_enable), 16'h0001);
        global_interrupt_enable <= 1'b1;
        foreach (rows[i]) begin
            wr_reg(ADDR_CAUSE, 8'h1F);
            pulse(rows[i].e);
            if (rows[i].kind == 2'd1) chk(16'(core_rst_n), 16'h0000);
            rd_chk(ADDR_CAUSE, rows[i].cause);
            rd_chk(ADDR_STATUS, rows[i].stat);
            if (rows[i].kind == 2'd1) wait_run(n);
            if (rows[i].kind != 2'd0) chk(16'(restart_addr), 16'(rows[i].addr));
        end
        chk(16'(push_seen), 16'h0001);
        // Two-cycle glitch on the pin must not get through the filter
        @(posedge clock) pin_low <= 1'b1;
        repeat (2) @(posedge clock);
        pin_low <= 1'b0;
        repeat (10) @(posedge clock);
        chk(16'(core_rst_n), 16'h0001);
        wr_reg(ADDR_CAUSE, 8'h1F);
        pulse(10'h002);
        evt.in_sleep <= 1'b1;
        pin_low      <= 1'b1;
        repeat (10) @(posedge clock);
        chk(16'(core_rst_n), 16'h0000);
        evt.in_sleep <= 1'b0;
        pin_low      <= 1'b0;
        rd_chk(ADDR_CAUSE, 8'h17);
        rd_chk(ADDR_STATUS, 8'h10);
        wait_run(n);
        for (int k = 0; k < 2; k++) begin
            wr_reg(ADDR_CAUSE, 8'h1F);
            @(posedge clock) {supply_low, lp_low} <= (k == 0) ? 2'b10 : 2'b01;
            repeat (8) @(posedge clock);
            chk(16'(core_rst_n), 16'h0000);
            {supply_low, lp_low} <= 2'b00;
            wait_run(n);
            chk(16'(n >= POWERUP_TIMER_SIM + 10), 16'h0001);
            rd_chk(ADDR_CAUSE, 8'h1E);
            rd_chk(ADDR_STATUS, STATUS_RST);
        end
        // Off-in-sleep mode: a low-power trip also re-arms power-on
        @(posedge clock) cfg.bormode <= BM_NOSLEEP;
        @(posedge clock) lp_low <= 1'b1;
        repeat (8) @(posedge clock);
        chk(16'({por_rearm, core_rst_n}), 16'h0002);
        lp_low <= 1'b0;
        wait_run(n);
        rd_chk(ADDR_CAUSE, 8'h1C);
        @(posedge clock) cfg.bormode <= BM_SW;
        repeat (2) @(posedge clock);
        chk(16'(bor_enable), 16'h0000);
        wr_reg(ADDR_BORCTL, 8'h80);
        repeat (2) @(posedge clock);
        chk(16'(bor_enable), 16'h0001);
        // Pin reset off: both enable bits low, pin becomes a plain input
        nrst <= 1'b0;
        cfg.master_clear_pin_en <= 1'b0;
        pin_low <= 1'b1;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        wait_run(n);
        chk(16'({gpio_in, pullup_en}), 16'h0000);
        @(posedge clock) {pin_low, sw_pullup_en} <= 2'b01;
        repeat (10) @(posedge clock);
        chk(16'({gpio_in, pullup_en, core_rst_n}), 16'h0007);
        stop_test();
    end
endmodule : test_reset_source_sequencer
`default_nettype wire
